// ### design/mch_device.sv
// Summary of operation
// - host drives rts low when able to receive
// - cts high after start, low when ready
// - host holds dtr low during data calls
// - dtr rising edge ends call, goes on-hook
// - dtr low: prepare modem, hold connection
// - dcd low only while connection exists
// - host powers module by pulling power low
// - ring event: ri low for 100 ms
// - shutdown line shared, module drives only confirming
// - host pulse, module confirms, releases, host unpowers
// - host transmit line idles high
// - hardware flow control enabled at start
`include "mch_cfg.svh"
module mch_device
  import mch_pkg::*;
(
  // clock, reset, enable
  input  wire logic REF_CLK,
  input  wire logic RST,
  input  wire logic CE,
  // link
  mch_if.dev        LINK,
  // modem core side
  input  wire logic RX_READY,
  input  wire logic LINE_CONNECTED,
  input  wire logic RING_EVENT,
  input  wire logic POWERDOWN_DONE,
  input  wire logic FLOW_CTRL_OFF,
  output logic      OFF_HOOK,
  output logic      TX_ALLOWED,
  output logic      SHUTDOWN_REQ,
  output logic      DATA_CALL
);

  typedef struct packed {
    logic [1:0] rts_s;
    logic [1:0] dtr_s;
    logic [1:0] pwr_s;
    logic [1:0] sd_s;
    logic       dtr_q;
    logic       sd_q;
    mch_call_t  call;
    mch_dsd_t   sdst;
    // 22 bits hold the 100 ms count at 20 MHz and up to about 41 MHz; a faster clock needs more
    mch_cnt_t   ring_cnt;
    mch_cnt_t   sd_cnt;
    logic       cts_n;
    logic       dcd_n;
    logic       ri_n;
    logic       flow_on;
    logic       sd_req;
  } mch_dev_st_t;

  mch_dev_st_t st;
  mch_dev_st_t next_st;

  logic rts_n;
  logic dtr_n;
  logic pwr_n;
  logic sd_in;
  logic rx_open;

  assign rts_n = st.rts_s[1];
  assign dtr_n = st.dtr_s[1];
  assign pwr_n = st.pwr_s[1];
  assign sd_in = st.sd_s[1];

  // ready only while powered, running and the core has room
  assign rx_open = RX_READY && !pwr_n && (st.sdst == MCH_SD_RUN);

  always_comb begin
    next_st = st;
    // two-stage synchronisers; stage 0 is read only by stage 1
    // this costs two cycles on every handshake, which the far end sees
    next_st.rts_s = {st.rts_s[0], LINK.rts_n};
    next_st.dtr_s = {st.dtr_s[0], LINK.dtr_n};
    next_st.pwr_s = {st.pwr_s[0], LINK.module_power_on_n};
    next_st.sd_s  = {st.sd_s[0], LINK.hard_shutdown_line};
    next_st.dtr_q = dtr_n;
    next_st.sd_q  = sd_in;
    next_st.flow_on = !FLOW_CTRL_OFF;
    next_st.sd_req  = 1'b0;

    next_st.cts_n = !rx_open;

    case (st.call)
      MCH_DEV_IDLE: begin
        if (!dtr_n) begin
          next_st.call = MCH_DEV_DIAL;
        end
      end
      MCH_DEV_DIAL: begin
        if (dtr_n) begin
          next_st.call = MCH_DEV_IDLE;
        end else if (LINE_CONNECTED) begin
          next_st.call = MCH_DEV_ONLINE;
        end
      end
      MCH_DEV_ONLINE: begin
        if (dtr_n && !st.dtr_q) begin
          next_st.call = MCH_DEV_IDLE;
        end else if (!LINE_CONNECTED) begin
          next_st.call = MCH_DEV_DIAL;
        end
      end
      default: begin
        next_st.call = MCH_DEV_IDLE;
      end
    endcase
    // without power the modem cannot hold a line: drop any call at once
    if (pwr_n) begin
      next_st.call = MCH_DEV_IDLE;
    end
    next_st.dcd_n = !(next_st.call == MCH_DEV_ONLINE);

    // an unpowered module reports no ring; a new event during an active
    // pulse restarts the full 100 ms
    if (pwr_n) begin
      next_st.ri_n     = 1'b1;
      next_st.ring_cnt = '0;
    end else if (RING_EVENT) begin
      next_st.ri_n     = 1'b0;
      next_st.ring_cnt = mch_cnt_t'(`MCH_RING_CYC - 1);
    end else if (!st.ri_n) begin
      if (st.ring_cnt == '0) begin
        next_st.ri_n = 1'b1;
      end else begin
        next_st.ring_cnt = st.ring_cnt - 1'b1;
      end
    end

    // shutdown: time the host's low pulse, confirm by holding the line
    // low once it ends, and let go when the core has powered down
    case (st.sdst)
      MCH_SD_RUN: begin
        if (pwr_n) begin
          // an unpowered module has nothing to shut down
          next_st.sd_cnt = '0;
        end else if (!sd_in) begin
          if (st.sd_cnt != '1) begin
            next_st.sd_cnt = st.sd_cnt + 1'b1;
          end
        end else begin
          next_st.sd_cnt = '0;
          // accept a low pulse at least the lower tolerance bound long
          if (!st.sd_q && st.sd_cnt >= mch_cnt_t'(`MCH_SD_MIN_CYC)) begin
            next_st.sdst   = MCH_SD_CONFIRM;
            next_st.sd_req = 1'b1;
          end
        end
      end
      MCH_SD_CONFIRM: begin
        if (POWERDOWN_DONE) begin
          next_st.sdst = MCH_SD_OFF;
        end else if (pwr_n) begin
          // power pulled early: the open-drain output goes with it
          next_st.sdst = MCH_SD_RUN;
        end
      end
      MCH_SD_OFF: begin
        // a fresh power-up (power line released, then asserted) restarts
        if (pwr_n) begin
          next_st.sdst = MCH_SD_RUN;
        end
      end
      default: begin
        next_st.sdst = MCH_SD_RUN;
      end
    endcase
  end

  // CE low freezes every stage, synchronisers included, so inputs are not sampled until CE returns
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      st       <= '0;
      st.rts_s <= 2'h3;
      st.dtr_s <= 2'h3;
      st.pwr_s <= 2'h3;
      st.sd_s  <= 2'h3;
      st.dtr_q <= 1'b1;
      st.sd_q  <= 1'b1;
      st.call  <= MCH_DEV_IDLE;
      st.sdst  <= MCH_SD_RUN;
      st.cts_n <= 1'b1;
      st.dcd_n <= 1'b1;
      st.ri_n  <= 1'b1;
      st.flow_on <= 1'b1;
    end else if (CE) begin
      st <= next_st;
    end
  end

  assign LINK.cts_n = st.cts_n;
  assign LINK.dcd_n = st.dcd_n;
  assign LINK.ri_n  = st.ri_n;
  // only ever pulls low, and only while confirming
  assign LINK.sd_dev_out = 1'b0;
  assign LINK.sd_dev_oe  = (st.sdst == MCH_SD_CONFIRM);
  assign OFF_HOOK     = (st.call != MCH_DEV_IDLE);
  assign DATA_CALL    = (st.call == MCH_DEV_ONLINE);
  // with flow control off the host's rts is ignored entirely
  assign TX_ALLOWED   = !st.flow_on || !rts_n;
  assign SHUTDOWN_REQ = st.sd_req;

endmodule

// ### design/mch_cfg.svh
`ifndef MCH_CFG_SVH
`define MCH_CFG_SVH

`define MCH_CLK_HZ          20000000
`define MCH_RING_MS         100
`define MCH_RING_CYC        (`MCH_CLK_HZ / 1000 * `MCH_RING_MS)
`define MCH_SD_NOM_MS       100
`define MCH_SD_TOL_MS       25
`define MCH_SD_MIN_CYC      (`MCH_CLK_HZ / 1000 * (`MCH_SD_NOM_MS - `MCH_SD_TOL_MS))
`define MCH_SD_PULSE_CYC    (`MCH_CLK_HZ / 1000 * `MCH_SD_NOM_MS)
`define MCH_CNT_W           22

`endif

// ### design/mch_pkg.sv
package mch_pkg;
  typedef logic [21:0] mch_cnt_t;

  typedef enum logic [1:0] {
    MCH_DEV_IDLE    = 2'b00,
    MCH_DEV_DIAL    = 2'b01,
    MCH_DEV_ONLINE  = 2'b10
  } mch_call_t;

  typedef enum logic [1:0] {
    MCH_SD_RUN      = 2'b00,
    MCH_SD_CONFIRM  = 2'b01,
    MCH_SD_OFF      = 2'b10
  } mch_dsd_t;

  typedef enum logic [2:0] {
    MCH_HS_OFF      = 3'b000,
    MCH_HS_ON       = 3'b001,
    MCH_HS_PULSE    = 3'b010,
    MCH_HS_WAITLOW  = 3'b011,
    MCH_HS_WAITHIGH = 3'b100
  } mch_hsd_t;
endpackage

// ### design/mch_if.sv
interface mch_if;
  logic rts_n;
  logic cts_n;
  logic dtr_n;
  logic dcd_n;
  logic ri_n;
  logic data_toward_module;
  logic module_power_on_n;
  logic sd_host_out;
  logic sd_host_oe;
  logic sd_dev_out;
  logic sd_dev_oe;
  logic hard_shutdown_line;

  // open-drain wire with the module's internal pull-up
  assign hard_shutdown_line = !((sd_host_oe && !sd_host_out) || (sd_dev_oe && !sd_dev_out));

  modport dev (
    input  rts_n, dtr_n, data_toward_module, module_power_on_n, hard_shutdown_line,
    output cts_n, dcd_n, ri_n, sd_dev_out, sd_dev_oe
  );
  modport host (
    input  cts_n, dcd_n, ri_n, hard_shutdown_line,
    output rts_n, dtr_n, data_toward_module, module_power_on_n, sd_host_out, sd_host_oe
  );
endinterface

// ### design/mch_host.sv
`include "mch_cfg.svh"
module mch_host
  import mch_pkg::*;
(
  // clock, reset, enable
  input  wire logic REF_CLK,
  input  wire logic RST,
  input  wire logic CE,
  // link
  mch_if.host       LINK,
  // application side
  input  wire logic APP_RX_READY,
  input  wire logic APP_CALL,
  input  wire logic APP_POWER,
  input  wire logic APP_SHUTDOWN,
  input  wire logic RING_ACK,
  output logic      MODULE_READY,
  output logic      CARRIER,
  output logic      RING_SEEN,
  output logic      POWERED,
  output logic      SHUTDOWN_BUSY
);

  typedef struct packed {
    logic [1:0] cts_s;
    logic [1:0] dcd_s;
    logic [1:0] ri_s;
    logic [1:0] sd_s;
    logic       ri_q;
    mch_hsd_t   hst;
    mch_cnt_t   cnt;
    logic       ring;
    logic       rts_n;
    logic       dtr_n;
    logic       ready;
    logic       carrier;
    logic       sd_rel;
  } mch_host_st_t;

  mch_host_st_t st;
  mch_host_st_t next_st;

  logic ri_n;
  logic sd_in;

  assign ri_n  = st.ri_s[1];
  assign sd_in = st.sd_s[1];

  always_comb begin
    next_st = st;
    next_st.cts_s = {st.cts_s[0], LINK.cts_n};
    next_st.dcd_s = {st.dcd_s[0], LINK.dcd_n};
    next_st.ri_s  = {st.ri_s[0], LINK.ri_n};
    next_st.sd_s  = {st.sd_s[0], LINK.hard_shutdown_line};
    next_st.ri_q  = ri_n;
    next_st.rts_n   = !APP_RX_READY;
    next_st.dtr_n   = !(APP_CALL && (st.hst == MCH_HS_ON));
    next_st.ready   = !st.cts_s[1];
    next_st.carrier = !st.dcd_s[1];

    // set wins over acknowledge
    if (!ri_n && st.ri_q) begin
      next_st.ring = 1'b1;
    end else if (RING_ACK) begin
      next_st.ring = 1'b0;
    end

    case (st.hst)
      MCH_HS_OFF: begin
        if (APP_POWER) begin
          next_st.hst = MCH_HS_ON;
        end
      end
      MCH_HS_ON: begin
        if (APP_SHUTDOWN) begin
          next_st.hst = MCH_HS_PULSE;
          next_st.cnt = mch_cnt_t'(`MCH_SD_PULSE_CYC - 1);
        end
      end
      MCH_HS_PULSE: begin
        if (st.cnt == '0) begin
          next_st.hst = MCH_HS_WAITLOW;
          next_st.sd_rel = 1'b0;
        end else begin
          next_st.cnt = st.cnt - 1'b1;
        end
      end
      MCH_HS_WAITLOW: begin
        // our own pulse still sits in the synchroniser: see the line high
        // first, so that only a later low counts as the module's confirm
        if (sd_in) begin
          next_st.sd_rel = 1'b1;
        end else if (st.sd_rel) begin
          next_st.hst = MCH_HS_WAITHIGH;
        end
      end
      MCH_HS_WAITHIGH: begin
        if (sd_in) begin
          next_st.hst = MCH_HS_OFF;
        end
      end
      default: begin
        next_st.hst = MCH_HS_OFF;
      end
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      st       <= '0;
      st.cts_s <= 2'h3;
      st.dcd_s <= 2'h3;
      st.ri_s  <= 2'h3;
      st.sd_s  <= 2'h3;
      st.ri_q  <= 1'b1;
      st.hst   <= MCH_HS_OFF;
      st.rts_n <= 1'b1;
      st.dtr_n <= 1'b1;
    end else if (CE) begin
      st <= next_st;
    end
  end

  assign LINK.rts_n              = st.rts_n;
  assign LINK.dtr_n              = st.dtr_n;
  assign LINK.data_toward_module = 1'b1;
  // power released again only after the module's confirm ended
  assign LINK.module_power_on_n  = (st.hst == MCH_HS_OFF);
  assign LINK.sd_host_out        = 1'b0;
  assign LINK.sd_host_oe         = (st.hst == MCH_HS_PULSE);
  assign MODULE_READY  = st.ready;
  assign CARRIER       = st.carrier;
  assign RING_SEEN     = st.ring;
  assign POWERED       = (st.hst != MCH_HS_OFF);
  assign SHUTDOWN_BUSY = (st.hst == MCH_HS_PULSE) || (st.hst == MCH_HS_WAITLOW)
                         || (st.hst == MCH_HS_WAITHIGH);

endmodule

// ### dv/mch_assertions.sv
`include "mch_cfg.svh"
module mch_assertions (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // link levels
  input wire logic cts_n,
  input wire logic dtr_n,
  input wire logic dcd_n,
  input wire logic ri_n,
  input wire logic module_power_on_n,
  input wire logic sd_host_oe,
  input wire logic sd_dev_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int RING_CYC = `MCH_RING_CYC;
  logic [21:0] ring_cnt;
  // low cycles of the ring line so far
  always_ff @(posedge REF_CLK) begin
    ring_cnt <= (RST || ri_n) ? 22'h0 : ring_cnt + 22'h1;
  end
  default clocking @(posedge REF_CLK);
  endclocking
  default disable iff (RST);
  property p_dev_reset;
    $fell(RST) |-> cts_n && dcd_n && ri_n && !sd_dev_oe;
  endproperty
  a_dev_reset: assert property (p_dev_reset) else $error("idle levels wrong");
  property p_cts_pwr;
    !cts_n |-> !module_power_on_n;
  endproperty
  a_cts_pwr: assert property (p_cts_pwr) else $error("ready unpowered");
  property p_dtr_pwr;
    !dtr_n |-> !module_power_on_n;
  endproperty
  a_dtr_pwr: assert property (p_dtr_pwr) else $error("call unpowered");
  property p_hangup;
    $rose(dtr_n) |-> ##[1:3] dcd_n;
  endproperty
  a_hangup: assert property (p_hangup) else $error("carrier after hangup");
  property p_dcd_call;
    !dcd_n |-> !$past(dtr_n, 3);
  endproperty
  a_dcd_call: assert property (p_dcd_call) else $error("carrier without call");
  property p_ring_start;
    $fell(ri_n) |=> !ri_n [*8];
  endproperty
  a_ring_start: assert property (p_ring_start) else $error("ring too short");
  property p_ring_len;
    $rose(ri_n) |-> ring_cnt >= RING_CYC;
  endproperty
  a_ring_len: assert property (p_ring_len) else $error("ring length wrong");
  property p_sd_pulse;
    $rose(sd_host_oe) |=> sd_host_oe [*8];
  endproperty
  a_sd_pulse: assert property (p_sd_pulse) else $error("shutdown pulse short");
  property p_pwr_release;
    $rose(module_power_on_n) |-> !sd_dev_oe && !sd_host_oe;
  endproperty
  a_pwr_release: assert property (p_pwr_release) else $error("power cut in confirm");
  property p_dev_drive;
    sd_dev_oe |-> !sd_host_oe;
  endproperty
  a_dev_drive: assert property (p_dev_drive) else $error("both ends pull shutdown");
endmodule

// ### dv/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic REF_CLK = 1'b0;
  logic RST = 1'b1;
  logic rx_rdy = 1'b0;
  logic line_up = 1'b0;
  logic ring_ev = 1'b0;
  logic flow_off = 1'b0;
  logic app_rx = 1'b0;
  logic app_call = 1'b0;
  logic app_pwr = 1'b0;
  logic app_sd = 1'b0;
  logic ring_ack = 1'b0;
  logic ce = 1'b1;
  logic pd_done = 1'b0;
  logic off_hook, tx_ok, data_call, mod_rdy, carrier, ring_seen, sd_busy;
  logic shut_req, powered;
  int fails = 0;
  int tests_run = 0;
  int cyc = 0;
  mch_if link ();
  mch_device mch_device_inst (
    .REF_CLK(REF_CLK), .RST(RST), .CE(ce), .LINK(link), .RX_READY(rx_rdy),
    .LINE_CONNECTED(line_up), .RING_EVENT(ring_ev), .POWERDOWN_DONE(pd_done),
    .FLOW_CTRL_OFF(flow_off), .OFF_HOOK(off_hook), .TX_ALLOWED(tx_ok),
    .SHUTDOWN_REQ(shut_req), .DATA_CALL(data_call)
  );
  mch_host mch_host_inst (
    .REF_CLK(REF_CLK), .RST(RST), .CE(ce), .LINK(link), .APP_RX_READY(app_rx),
    .APP_CALL(app_call), .APP_POWER(app_pwr), .APP_SHUTDOWN(app_sd),
    .RING_ACK(ring_ack), .MODULE_READY(mod_rdy), .CARRIER(carrier),
    .RING_SEEN(ring_seen), .POWERED(powered), .SHUTDOWN_BUSY(sd_busy)
  );
  mch_assertions mch_assertions_inst (
    .REF_CLK(REF_CLK), .RST(RST), .cts_n(link.cts_n), .dtr_n(link.dtr_n),
    .dcd_n(link.dcd_n), .ri_n(link.ri_n), .module_power_on_n(link.module_power_on_n),
    .sd_host_oe(link.sd_host_oe), .sd_dev_oe(link.sd_dev_oe)
  );
  always #25 REF_CLK = ~REF_CLK;
  task automatic step(input int n);
    repeat (n) @(posedge REF_CLK);
    #5;
  endtask
  task automatic chk(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got %b exp %b", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge REF_CLK) begin
    cyc++;
    if (cyc == 10000) begin
      fails++;
      complete_run();
    end
  end
  initial begin
    step(20);
    RST = 1'b0;
    chk(link.cts_n, 1'b1);
    chk(link.dcd_n, 1'b1);
    chk(link.data_toward_module, 1'b1);
    $display("test reset done");
    app_pwr = 1'b1;
    rx_rdy = 1'b1;
    step(1);
    chk(link.module_power_on_n, 1'b0);
    chk(powered, 1'b1);
    step(10);
    chk(link.cts_n, 1'b0);
    chk(mod_rdy, 1'b1);
    chk(tx_ok, 1'b0);
    app_rx = 1'b1;
    step(6);
    chk(link.rts_n, 1'b0);
    chk(tx_ok, 1'b1);
    app_rx = 1'b0;
    flow_off = 1'b1;
    step(6);
    chk(link.rts_n, 1'b1);
    chk(tx_ok, 1'b1);
    flow_off = 1'b0;
    $display("test flow done");
    // a frozen host must not pass the new readiness on
    ce = 1'b0;
    app_rx = 1'b1;
    step(6);
    chk(link.rts_n, 1'b1);
    ce = 1'b1;
    step(6);
    chk(link.rts_n, 1'b0);
    chk(tx_ok, 1'b1);
    app_rx = 1'b0;
    $display("test enable done");
    app_call = 1'b1;
    step(6);
    chk(link.dtr_n, 1'b0);
    chk(off_hook, 1'b1);
    line_up = 1'b1;
    step(6);
    chk(link.dcd_n, 1'b0);
    chk(data_call, 1'b1);
    chk(carrier, 1'b1);
    line_up = 1'b0;
    step(6);
    chk(link.dcd_n, 1'b1);
    chk(off_hook, 1'b1);
    line_up = 1'b1;
    step(6);
    app_call = 1'b0;
    step(6);
    chk(off_hook, 1'b0);
    chk(link.dcd_n, 1'b1);
    line_up = 1'b0;
    $display("test call done");
    ring_ev = 1'b1;
    step(1);
    ring_ev = 1'b0;
    chk(link.ri_n, 1'b0);
    step(4);
    chk(ring_seen, 1'b1);
    ring_ack = 1'b1;
    step(1);
    ring_ack = 1'b0;
    step(1000);
    chk(ring_seen, 1'b0);
    chk(link.ri_n, 1'b0);
    // a second event restarts the pulse without a fresh falling edge
    ring_ev = 1'b1;
    step(1);
    ring_ev = 1'b0;
    step(4);
    chk(link.ri_n, 1'b0);
    chk(ring_seen, 1'b0);
    $display("test ring done");
    // full pulses run two million cycles, so only their start is seen here
    app_sd = 1'b1;
    step(1);
    chk(link.hard_shutdown_line, 1'b0);
    chk(sd_busy, 1'b1);
    pd_done = 1'b1;
    step(2000);
    chk(link.sd_host_oe, 1'b1);
    chk(link.sd_dev_oe, 1'b0);
    chk(shut_req, 1'b0);
    pd_done = 1'b0;
    $display("test shutdown done");
    complete_run();
  end
endmodule
